// >>> flash_read_config_register_test.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module flash_read_config_register_test import frcr_pkg::*; ;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic lclk, cs_n, si, so, oe, wt, rd, xip, rx_t;
    logic xf = 1'b0;
    logic [23:0] addr;
    logic [7:0] mdat = 8'h00;
    logic [7:0] setup, rx_d, e_rx;
    logic [1:0] nv = 2'h3;
    logic [1:0] wrap;
    logic [3:0] dum;
    frcr_proto_t proto;
    logic [7:0] exp_q[$];
    int num_errors = 0;
    int n_compared = 0;
    int seed = 53;
    always #50 clk_in = ~clk_in;
    // off-cycle data is scrambled so a late sample shows up
    always @(posedge clk_in) mdat <= rd ? addr[7:0] ^ 8'h3C : ~mdat;
    frcr_top i_dut (.clk_in, .rst_n_in, .link_clk_in(lclk), .link_cs_n_in(cs_n),
        .link_si_in(si), .link_so_out(so), .link_so_oe_out(oe), .link_wait_out(wt),
        .mem_addr_out(addr), .mem_rd_out(rd), .mem_data_in(mdat), .nv_proto_bits_in(nv),
        .xip_fixed_in(xf), .dummy_cycles_out(dum), .wrap_mode_out(wrap),
        .xip_active_out(xip), .protocol_out(proto), .read_setup_out(setup));
    frcr_host u_host (.link_clk_out(lclk), .link_cs_n_out(cs_n), .link_si_out(si),
        .link_so_in(so), .link_so_oe_in(oe), .link_wait_in(wt), .rx_data_out(rx_d),
        .rx_tgl_out(rx_t));
    function automatic logic [3:0] dexp(input logic [3:0] c);
        return (c == 4'h0 || c == 4'hF) ? 4'hA : c;
    endfunction
    task automatic close_out();
        if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic do_reset(input logic [2:0] s);
        @(posedge clk_in) rst_n_in <= 1'b0;
        nv <= s[1:0];
        xf <= s[2];
        repeat (8) @(posedge clk_in);
        #30 rst_n_in = 1'b1;
        repeat (5) @(posedge clk_in);
    endtask
    always @(rx_t) begin
        if (rst_n_in) begin
            e_rx = (exp_q.size() > 0) ? exp_q.pop_front() : ~rx_d;
            `CHK("rx byte", e_rx, rx_d)
        end
    end
    initial begin
        #3000000;
        num_errors++;
        close_out();
    end
    initial begin
        logic [7:0] v;
        logic [23:0] a, st;
        int d;
        int sz;
        for (int s = 7; s >= 0; s--) begin
            do_reset(s[2:0]);
            `CHK("setup", VRS_RESET, setup)
            `CHK("dummy", 4'hA, dum)
            `CHK("wrap", WRAP_SEQ, wrap)
            `CHK("xip", s[2], xip)
            `CHK("proto", !s[1] ? FRCR_PROTO_QUAD : !s[0] ? FRCR_PROTO_DUAL : FRCR_PROTO_EXT,
                proto)
        end
        for (int i = 0; i < 6; i++) begin
            v = 8'($random(seed));
            v[3] = 1'b1;
            if (i < 2) v[7:4] = {4{i[0]}};
            u_host.wr_setup(v);
            `CHK("setup", v & 8'hFB, setup)
            `CHK("dummy", dexp(v[7:4]), dum)
            `CHK("wrap", v[1:0], wrap)
            `CHK("xip", 1'b0, xip)
            exp_q.push_back(v & 8'hFB);
            u_host.rd_setup();
        end
        for (int w = 0; w < 4; w++) begin
            v = {(w == 0) ? 4'h0 : (w == 3) ? 4'hF : 4'(3 * w), 2'b10, w[1:0]};
            u_host.wr_setup(v);
            sz = 16 << w;
            st = (w == 3) ? 24'hFFFFFE : 24'h123400 + 24'(sz - 2);
            a = st;
            for (int k = 0; k < 4; k++) begin
                exp_q.push_back(a[7:0] ^ 8'h3C);
                a = (w == 3) ? a + 24'h1 : (a & ~24'(sz - 1)) | ((a + 24'h1) & 24'(sz - 1));
            end
            u_host.fast(1'b1, st, 4, d);
            `CHK("dummies", dexp(v[7:4]), 4'(d))
        end
        u_host.wr_setup(8'h21);
        `CHK("xip", 1'b1, xip)
        exp_q = {8'h1F ^ 8'h3C, 8'h00 ^ 8'h3C, 8'h40 ^ 8'h3C, 8'h41 ^ 8'h3C};
        u_host.fast(1'b1, 24'h00001F, 2, d);
        u_host.fast(1'b0, 24'h000040, 2, d);
        `CHK("left", 0, exp_q.size())
        close_out();
    end
endmodule
bind frcr_top frcr_checker u_chk (.clk_in, .rst_n_in, .link_clk_in, .link_cs_n_in,
    .link_so_oe_out, .mem_addr_out, .mem_rd_out, .nv_proto_bits_in, .xip_fixed_in,
    .dummy_cycles_out, .wrap_mode_out, .xip_active_out, .protocol_out, .read_setup_out);

// >>> frcr_buf2.sv
`timescale 1ns/10ps
module frcr_buf2 import frcr_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic flush_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [TX_W-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [TX_W-1:0] out_data_out
);
    localparam int DEPTH = 2;

    logic [TX_W-1:0] mem_reg [DEPTH];
    logic [TX_W-1:0] mem_next [DEPTH];
    logic wr_ptr_reg, wr_ptr_next;
    logic rd_ptr_reg, rd_ptr_next;
    logic [1:0] count_reg, count_next;
    logic push, pop;

    assign in_ready_out = (count_reg != 2'h2);
    assign out_valid_out = (count_reg != 2'h0);
    assign out_data_out = mem_reg[rd_ptr_reg];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb begin
        mem_next = mem_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next = count_reg;
        if (flush_in) begin
            wr_ptr_next = 1'b0;
            rd_ptr_next = 1'b0;
            count_next = 2'h0;
        end else begin
            if (push) begin
                mem_next[wr_ptr_reg] = in_data_in;
                wr_ptr_next = ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_next = ~rd_ptr_reg;
            end
            if (push && !pop) begin
                count_next = count_reg + 2'h1;
            end else if (pop && !push) begin
                count_next = count_reg - 2'h1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            mem_reg <= mem_next;
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
        end
    end
endmodule

// >>> frcr_checker.sv
`timescale 1ns/10ps
module frcr_checker import frcr_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic link_clk_in,
    input wire logic link_cs_n_in,
    input wire logic link_so_oe_out,
    input wire logic [ADDR_W-1:0] mem_addr_out,
    input wire logic mem_rd_out,
    input wire logic [1:0] nv_proto_bits_in,
    input wire logic xip_fixed_in,
    input wire logic [3:0] dummy_cycles_out,
    input wire logic [1:0] wrap_mode_out,
    input wire logic xip_active_out,
    input frcr_proto_t protocol_out,
    input wire logic [VRS_W-1:0] read_setup_out
);
    logic [1:0] cyc_reg, cyc_next;
    logic have_reg, have_next;
    logic [23:0] prev_reg, prev_next, mask;
    always_comb begin
        cyc_next = (cyc_reg == 2'h3) ? cyc_reg : cyc_reg + 2'h1;
        have_next = mem_rd_out | (have_reg & ~link_cs_n_in);
        prev_next = mem_rd_out ? mem_addr_out : prev_reg;
        mask = (wrap_mode_out == 2'h3) ? 24'hFFFFFF : 24'h00003F >> (2'h2 - wrap_mode_out);
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cyc_reg <= 2'h0;
            have_reg <= 1'b0;
            prev_reg <= 24'h000000;
        end else begin
            cyc_reg <= cyc_next;
            have_reg <= have_next;
            prev_reg <= prev_next;
        end
    end
    // straps pass a synchroniser, so judge them only once settled
    sequence s_settled;
        cyc_reg == 2'h3;
    endsequence
    sequence s_next_rd;
        mem_rd_out && have_reg;
    endsequence
    property p_dummy;
        @(posedge clk_in) disable iff (!rst_n_in) dummy_cycles_out == ((read_setup_out[7:4]
            == 4'h0 || read_setup_out[7:4] == 4'hF) ? 4'hA : read_setup_out[7:4]);
    endproperty
    a_dummy: assert property (p_dummy) else $error("dummy count decode wrong");
    property p_wrap;
        @(posedge clk_in) disable iff (!rst_n_in) wrap_mode_out == read_setup_out[1:0];
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap field wrong");
    property p_rsvd;
        @(posedge clk_in) disable iff (!rst_n_in) read_setup_out[RSVD_BIT] == 1'b0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    property p_oe_idle;
        @(posedge link_clk_in) disable iff (!rst_n_in) link_cs_n_in |-> !link_so_oe_out;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("output driven outside frame");
    property p_addr_step;
        @(posedge clk_in) disable iff (!rst_n_in)
            s_next_rd |-> mem_addr_out == ((prev_reg & ~mask) | ((prev_reg + 24'h1) & mask));
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("read address step wrong");
    property p_proto;
        @(posedge clk_in) disable iff (!rst_n_in) s_settled |-> protocol_out ==
            (!nv_proto_bits_in[1] ? FRCR_PROTO_QUAD : !nv_proto_bits_in[0] ?
            FRCR_PROTO_DUAL : FRCR_PROTO_EXT);
    endproperty
    a_proto: assert property (p_proto) else $error("protocol select wrong");
    property p_xip_fixed;
        @(posedge clk_in) disable iff (!rst_n_in) s_settled ##0 xip_fixed_in |-> xip_active_out;
    endproperty
    a_xip_fixed: assert property (p_xip_fixed) else $error("fixed variant not in xip");
    property p_xip_bit;
        @(posedge clk_in) disable iff (!rst_n_in)
            s_settled ##0 !xip_fixed_in |-> xip_active_out == !read_setup_out[XIP_BIT];
    endproperty
    a_xip_bit: assert property (p_xip_bit) else $error("xip state wrong");
endmodule

// >>> frcr_host.sv
`timescale 1ns/10ps
module frcr_host import frcr_pkg::*; (
    output logic link_clk_out,
    output logic link_cs_n_out = 1'b1,
    output logic link_si_out = 1'b0,
    input wire logic link_so_in,
    input wire logic link_so_oe_in,
    input wire logic link_wait_in,
    output logic [7:0] rx_data_out = 8'h00,
    output logic rx_tgl_out = 1'b0
);
    logic free = 1'b0;
    logic run = 1'b0;
    // single rate, 83 MHz: within limits for every dummy count used
    initial #3.3 forever #6 free = ~free;
    assign link_clk_out = free & run;
    task automatic open_f();
        @(negedge free);
        run = 1'b1;
    endtask
    task automatic close_f();
        @(negedge free);
        link_cs_n_out = 1'b1;
        link_si_out = ~link_si_out;
        repeat (50) @(posedge free);
        @(negedge free);
        run = 1'b0;
        #500;
    endtask
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(negedge free);
            link_cs_n_out = 1'b0;
            link_si_out = b[i];
            do @(posedge free); while (link_wait_in);
        end
    endtask
    task automatic recv(inout int d);
        int n = 0;
        while (n < 8) begin
            @(posedge free);
            if (!link_wait_in && link_so_oe_in) begin
                rx_data_out[7-n] = link_so_in;
                n++;
            end else if (!link_wait_in) begin
                d++;
            end
        end
        rx_tgl_out = ~rx_tgl_out;
    endtask
    task automatic wr_setup(input logic [7:0] v);
        open_f();
        send(OP_WRITE_VRS);
        send(v);
        close_f();
    endtask
    task automatic rd_setup();
        int d = 0;
        open_f();
        send(OP_READ_VRS);
        recv(d);
        close_f();
    endtask
    task automatic fast(input logic op, input logic [23:0] a, input int nb, output int d);
        d = 0;
        open_f();
        if (op) send(OP_FAST_READ);
        send(a[23:16]);
        send(a[15:8]);
        send(a[7:0]);
        repeat (nb) recv(d);
        close_f();
    endtask
endmodule

// >>> frcr_pkg.sv
package frcr_pkg;

    // read setup register layout
    localparam int VRS_W = 8;
    localparam int DUMMY_MSB = 7;
    localparam int DUMMY_LSB = 4;
    localparam int XIP_BIT = 3;
    localparam int RSVD_BIT = 2;
    localparam int WRAP_MSB = 1;
    localparam int WRAP_LSB = 0;
    localparam logic [7:0] VRS_RESET = 8'hFB;

    // dummy count codes
    localparam logic [3:0] DUMMY_CODE_LOW = 4'h0;
    localparam logic [3:0] DUMMY_CODE_HIGH = 4'hF;
    localparam logic [3:0] DUMMY_DEFAULT = 4'hA;

    // wrap codes
    localparam logic [1:0] WRAP_16 = 2'h0;
    localparam logic [1:0] WRAP_32 = 2'h1;
    localparam logic [1:0] WRAP_64 = 2'h2;
    localparam logic [1:0] WRAP_SEQ = 2'h3;
    localparam logic [23:0] WRAP_16_MASK = 24'h00000F;
    localparam logic [23:0] WRAP_32_MASK = 24'h00001F;
    localparam logic [23:0] WRAP_64_MASK = 24'h00003F;
    localparam logic [23:0] WRAP_SEQ_MASK = 24'hFFFFFF;

    localparam int ADDR_W = 24;
    localparam logic [1:0] ADDR_LAST = 2'h2;

    // command codes, values arbitrary
    localparam logic [7:0] OP_WRITE_VRS = 8'hA1;
    localparam logic [7:0] OP_READ_VRS = 8'hA5;
    localparam logic [7:0] OP_FAST_READ = 8'hB0;

    // nonvolatile protocol bits as presented on the strap input
    localparam int NV_QUAD_BIT = 1;
    localparam int NV_DUAL_BIT = 0;

    // item sent to the link: bit 8 marks a dummy run, low nibble its length
    localparam int TX_W = 9;
    localparam int TX_DUMMY_BIT = 8;
    localparam logic [2:0] LINK_LAST_BIT = 3'h7;

    typedef enum logic [1:0] {
        FRCR_PROTO_EXT,
        FRCR_PROTO_DUAL,
        FRCR_PROTO_QUAD
    } frcr_proto_t;

    function automatic logic [3:0] frcr_dummy_cycles(input logic [3:0] code);
        if (code == DUMMY_CODE_LOW || code == DUMMY_CODE_HIGH) begin
            return DUMMY_DEFAULT;
        end
        return code;
    endfunction

    function automatic logic [23:0] frcr_next_addr(input logic [23:0] a, input logic [1:0] w);
        logic [23:0] m;
        logic [23:0] inc;
        unique case (w)
            WRAP_16: m = WRAP_16_MASK;
            WRAP_32: m = WRAP_32_MASK;
            WRAP_64: m = WRAP_64_MASK;
            WRAP_SEQ: m = WRAP_SEQ_MASK;
        endcase
        inc = a + 24'h000001;
        return (a & ~m) | (inc & m);
    endfunction

endpackage

// >>> frcr_top.sv
// Functional notes
// - bits 7:4 of read setup set dummy cycles after each fast read address
// - dummy codes 0000 and 1111 both mean the default count for 108 MHz
// - bit 3 cleared enables execute-in-place; fixed variants ignore it and stay in it
// - wrap codes 00/01/10 wrap within aligned 16/32/64 byte block
// - wrap code 11, the default, reads sequentially through memory
// - wrapped bytes rise to block end then resume at block start
// - a write of read setup takes effect at once
// - read setup is read and written only by its own commands
// - both protocol bits zero or bit 1 zero give quad, bit 0 zero alone dual
// - protocol bits active low, default ones select extended single line
`timescale 1ns/10ps
module frcr_top import frcr_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic link_clk_in,
    input wire logic link_cs_n_in,
    input wire logic link_si_in,
    output logic link_so_out,
    output logic link_so_oe_out,
    output logic link_wait_out,
    output logic [ADDR_W-1:0] mem_addr_out,
    output logic mem_rd_out,
    input wire logic [7:0] mem_data_in,
    input wire logic [1:0] nv_proto_bits_in,
    input wire logic xip_fixed_in,
    output logic [3:0] dummy_cycles_out,
    output logic [1:0] wrap_mode_out,
    output logic xip_active_out,
    output frcr_proto_t protocol_out,
    output logic [VRS_W-1:0] read_setup_out
);
    typedef enum logic [3:0] {
        S_IDLE, S_CMD, S_WRREG, S_RDREG, S_ADDR, S_DUMMY, S_FETCH, S_LOAD, S_PUSH, S_DONE
    } frcr_core_st_t;

    // ---------------- core domain ----------------
    frcr_core_st_t st_reg, st_next;
    logic [VRS_W-1:0] vrs_reg, vrs_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [1:0] acnt_reg, acnt_next;
    logic [7:0] byte_reg, byte_next;
    logic xip_cont_reg, xip_cont_next;
    logic mem_rd_reg, mem_rd_next;
    logic tx_busy_reg, tx_busy_next;
    logic tx_tgl_reg, tx_tgl_next;
    logic [TX_W-1:0] tx_data_reg, tx_data_next;
    logic rx_ack_tgl_reg, rx_ack_tgl_next;
    logic strap_done_reg, strap_done_next;
    frcr_proto_t proto_reg, proto_next;
    logic xip_fixed_reg, xip_fixed_next;

    // synchronisers into the core clock
    logic cs_m_reg, cs_s_reg;
    logic rx_m_reg, rx_s_reg;
    logic txack_m_reg, txack_s_reg, txack_d_reg;
    logic [1:0] nv_m_reg, nv_s_reg;
    logic xf_m_reg, xf_s_reg;

    // link domain state
    logic [7:0] lk_sh_reg, lk_sh_next;
    logic [2:0] lk_bit_reg, lk_bit_next;
    logic lk_so_reg, lk_so_next;
    logic lk_tx_act_reg, lk_tx_act_next;
    logic lk_dmy_reg, lk_dmy_next;
    logic [3:0] lk_dcnt_reg, lk_dcnt_next;
    logic lk_rx_pend_reg, lk_rx_pend_next;
    logic lk_rx_tgl_reg, lk_rx_tgl_next;
    logic [7:0] lk_rx_hold_reg, lk_rx_hold_next;
    logic lk_ack_tgl_reg, lk_ack_tgl_next;
    logic lk_req_m_reg, lk_req_s_reg, lk_req_d_reg;
    logic lk_rxack_m_reg, lk_rxack_s_reg, lk_rxack_d_reg;
    logic lk_phase_m_reg, lk_phase_s_reg;

    logic frame, rx_new, tx_acked, xip_active, tx_phase;
    logic push_valid, push_ready, buf_valid;
    logic [TX_W-1:0] push_data, buf_data;
    logic lk_req_new, lk_rxack_new;

    assign frame = !cs_s_reg;
    assign rx_new = rx_s_reg ^ rx_ack_tgl_reg;
    assign tx_acked = txack_s_reg ^ txack_d_reg;
    // fixed variants run execute-in-place whatever bit 3 holds
    assign xip_active = xip_fixed_reg || !vrs_reg[XIP_BIT];
    assign tx_phase = (st_reg == S_RDREG) || (st_reg == S_DUMMY) || (st_reg == S_FETCH)
        || (st_reg == S_LOAD) || (st_reg == S_PUSH);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cs_m_reg <= 1'b1;
            cs_s_reg <= 1'b1;
            rx_m_reg <= 1'b0;
            rx_s_reg <= 1'b0;
            txack_m_reg <= 1'b0;
            txack_s_reg <= 1'b0;
            txack_d_reg <= 1'b0;
        end else begin
            cs_m_reg <= link_cs_n_in;
            cs_s_reg <= cs_m_reg;
            rx_m_reg <= lk_rx_tgl_reg;
            rx_s_reg <= rx_m_reg;
            txack_m_reg <= lk_ack_tgl_reg;
            txack_s_reg <= txack_m_reg;
            txack_d_reg <= txack_s_reg;
        end
    end

    // straps keep sampling through reset, so they have settled at release
    always_ff @(posedge clk_in) begin
        nv_m_reg <= nv_proto_bits_in;
        nv_s_reg <= nv_m_reg;
        xf_m_reg <= xip_fixed_in;
        xf_s_reg <= xf_m_reg;
    end

    always_comb begin
        st_next = st_reg;
        vrs_next = vrs_reg;
        addr_next = addr_reg;
        acnt_next = acnt_reg;
        byte_next = byte_reg;
        xip_cont_next = xip_cont_reg;
        mem_rd_next = 1'b0;
        tx_busy_next = tx_busy_reg;
        tx_tgl_next = tx_tgl_reg;
        tx_data_next = tx_data_reg;
        rx_ack_tgl_next = rx_ack_tgl_reg;
        strap_done_next = 1'b1;
        proto_next = proto_reg;
        xip_fixed_next = xip_fixed_reg;
        push_valid = 1'b0;
        push_data = '0;
        // straps are caught once, the first cycle after reset release
        if (!strap_done_reg) begin
            xip_fixed_next = xf_s_reg;
            if (!nv_s_reg[NV_QUAD_BIT]) begin
                proto_next = FRCR_PROTO_QUAD;
            end else if (!nv_s_reg[NV_DUAL_BIT]) begin
                proto_next = FRCR_PROTO_DUAL;
            end else begin
                proto_next = FRCR_PROTO_EXT;
            end
        end
        if (rx_new && (st_reg != S_IDLE || !frame)) begin
            rx_ack_tgl_next = ~rx_ack_tgl_reg;
        end
        // link item handshake: a new item only once the last one is acknowledged
        if (tx_acked) begin
            tx_busy_next = 1'b0;
        end else if (buf_valid && !tx_busy_reg) begin
            tx_busy_next = 1'b1;
            tx_tgl_next = ~tx_tgl_reg;
            tx_data_next = buf_data;
        end
        unique case (st_reg)
            S_IDLE: begin
                // a stale item must drain before a new frame can start
                if (frame && !tx_busy_reg) begin
                    acnt_next = 2'h0;
                    st_next = (xip_active && xip_cont_reg) ? S_ADDR : S_CMD;
                end
            end
            S_CMD: begin
                if (rx_new) begin
                    unique case (lk_rx_hold_reg)
                        OP_WRITE_VRS: st_next = S_WRREG;
                        OP_READ_VRS: st_next = S_RDREG;
                        OP_FAST_READ: st_next = S_ADDR;
                        default: st_next = S_DONE;
                    endcase
                end
            end
            S_WRREG: begin
                if (rx_new) begin
                    vrs_next = lk_rx_hold_reg;
                    vrs_next[RSVD_BIT] = 1'b0;
                    st_next = S_DONE;
                end
            end
            S_RDREG: begin
                // register repeats while the host keeps clocking
                push_valid = 1'b1;
                push_data = {1'b0, vrs_reg};
            end
            S_ADDR: begin
                if (rx_new) begin
                    addr_next = {addr_reg[ADDR_W-9:0], lk_rx_hold_reg};
                    acnt_next = acnt_reg + 2'h1;
                    if (acnt_reg == ADDR_LAST) begin
                        st_next = S_DUMMY;
                    end
                end
            end
            S_DUMMY: begin
                push_valid = 1'b1;
                push_data = {1'b1, 4'h0, frcr_dummy_cycles(vrs_reg[DUMMY_MSB:DUMMY_LSB])};
                if (push_ready) begin
                    st_next = S_FETCH;
                end
            end
            S_FETCH: begin
                mem_rd_next = 1'b1;
                st_next = S_LOAD;
            end
            S_LOAD: begin
                // mem_rd_out is registered, data arrives one cycle after it
                if (mem_rd_reg == 1'b0) begin
                    byte_next = mem_data_in;
                    st_next = S_PUSH;
                end
            end
            S_PUSH: begin
                push_valid = 1'b1;
                push_data = {1'b0, byte_reg};
                if (push_ready) begin
                    addr_next = frcr_next_addr(addr_reg, vrs_reg[WRAP_MSB:WRAP_LSB]);
                    xip_cont_next = xip_active;
                    st_next = S_FETCH;
                end
            end
            S_DONE: begin
            end
        endcase
        if (!frame && st_reg != S_IDLE) begin
            st_next = S_IDLE;
            if (!xip_active) begin
                xip_cont_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= S_IDLE;
            vrs_reg <= VRS_RESET;
            addr_reg <= '0;
            acnt_reg <= 2'h0;
            byte_reg <= 8'h00;
            xip_cont_reg <= 1'b0;
            mem_rd_reg <= 1'b0;
            tx_busy_reg <= 1'b0;
            tx_tgl_reg <= 1'b0;
            tx_data_reg <= '0;
            rx_ack_tgl_reg <= 1'b0;
            strap_done_reg <= 1'b0;
            proto_reg <= FRCR_PROTO_EXT;
            xip_fixed_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            vrs_reg <= vrs_next;
            addr_reg <= addr_next;
            acnt_reg <= acnt_next;
            byte_reg <= byte_next;
            xip_cont_reg <= xip_cont_next;
            mem_rd_reg <= mem_rd_next;
            tx_busy_reg <= tx_busy_next;
            tx_tgl_reg <= tx_tgl_next;
            tx_data_reg <= tx_data_next;
            rx_ack_tgl_reg <= rx_ack_tgl_next;
            strap_done_reg <= strap_done_next;
            proto_reg <= proto_next;
            xip_fixed_reg <= xip_fixed_next;
        end
    end

    frcr_buf2 u_buf (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .flush_in(!frame),
        .in_valid_in(push_valid),
        .in_ready_out(push_ready),
        .in_data_in(push_data),
        .out_valid_out(buf_valid),
        .out_ready_in(!tx_busy_reg),
        .out_data_out(buf_data)
    );

    assign mem_addr_out = addr_reg;
    assign mem_rd_out = mem_rd_reg;
    assign read_setup_out = vrs_reg;
    assign dummy_cycles_out = frcr_dummy_cycles(vrs_reg[DUMMY_MSB:DUMMY_LSB]);
    assign wrap_mode_out = vrs_reg[WRAP_MSB:WRAP_LSB];
    assign xip_active_out = xip_active;
    assign protocol_out = proto_reg;

    // ---------------- link domain ----------------
    assign lk_req_new = lk_req_s_reg ^ lk_req_d_reg;
    assign lk_rxack_new = lk_rxack_s_reg ^ lk_rxack_d_reg;
    // host holds its bits while wait is high; cycles then do not count
    assign link_wait_out = !link_cs_n_in
        && (lk_rx_pend_reg || (lk_phase_s_reg && !lk_tx_act_reg));
    assign link_so_oe_out = !link_cs_n_in && lk_tx_act_reg && !lk_dmy_reg;
    assign link_so_out = lk_so_reg;

    always_ff @(posedge link_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lk_req_m_reg <= 1'b0;
            lk_req_s_reg <= 1'b0;
            lk_req_d_reg <= 1'b0;
            lk_rxack_m_reg <= 1'b0;
            lk_rxack_s_reg <= 1'b0;
            lk_rxack_d_reg <= 1'b0;
            lk_phase_m_reg <= 1'b0;
            lk_phase_s_reg <= 1'b0;
        end else begin
            lk_req_m_reg <= tx_tgl_reg;
            lk_req_s_reg <= lk_req_m_reg;
            lk_req_d_reg <= lk_req_s_reg;
            lk_rxack_m_reg <= rx_ack_tgl_reg;
            lk_rxack_s_reg <= lk_rxack_m_reg;
            lk_rxack_d_reg <= lk_rxack_s_reg;
            lk_phase_m_reg <= tx_phase;
            lk_phase_s_reg <= lk_phase_m_reg;
        end
    end

    always_comb begin
        lk_sh_next = lk_sh_reg;
        lk_bit_next = lk_bit_reg;
        lk_so_next = lk_so_reg;
        lk_tx_act_next = lk_tx_act_reg;
        lk_dmy_next = lk_dmy_reg;
        lk_dcnt_next = lk_dcnt_reg;
        lk_rx_pend_next = lk_rx_pend_reg;
        lk_rx_tgl_next = lk_rx_tgl_reg;
        lk_rx_hold_next = lk_rx_hold_reg;
        lk_ack_tgl_next = lk_ack_tgl_reg;
        if (lk_rxack_new) begin
            lk_rx_pend_next = 1'b0;
        end
        if (link_cs_n_in) begin
            // outside a frame items are acknowledged and dropped
            lk_bit_next = 3'h0;
            lk_tx_act_next = 1'b0;
            if (lk_req_new || lk_tx_act_reg) begin
                lk_ack_tgl_next = ~lk_ack_tgl_reg;
            end
        end else if (lk_req_new) begin
            lk_tx_act_next = 1'b1;
            lk_dmy_next = tx_data_reg[TX_DUMMY_BIT];
            lk_dcnt_next = tx_data_reg[3:0];
            lk_so_next = tx_data_reg[7];
            lk_sh_next = {tx_data_reg[6:0], 1'b0};
            lk_bit_next = LINK_LAST_BIT;
        end else if (lk_tx_act_reg && lk_dmy_reg) begin
            lk_dcnt_next = lk_dcnt_reg - 4'h1;
            if (lk_dcnt_reg == 4'h1) begin
                lk_tx_act_next = 1'b0;
                lk_ack_tgl_next = ~lk_ack_tgl_reg;
            end
        end else if (lk_tx_act_reg) begin
            if (lk_bit_reg != 3'h0) begin
                lk_so_next = lk_sh_reg[7];
                lk_sh_next = {lk_sh_reg[6:0], 1'b0};
                lk_bit_next = lk_bit_reg - 3'h1;
            end else begin
                lk_tx_act_next = 1'b0;
                lk_ack_tgl_next = ~lk_ack_tgl_reg;
            end
        end else if (!lk_phase_s_reg && !lk_rx_pend_reg) begin
            lk_sh_next = {lk_sh_reg[6:0], link_si_in};
            lk_bit_next = lk_bit_reg + 3'h1;
            if (lk_bit_reg == LINK_LAST_BIT) begin
                lk_rx_hold_next = {lk_sh_reg[6:0], link_si_in};
                lk_rx_tgl_next = ~lk_rx_tgl_reg;
                lk_rx_pend_next = 1'b1;
            end
        end
    end

    always_ff @(posedge link_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lk_sh_reg <= 8'h00;
            lk_bit_reg <= 3'h0;
            lk_so_reg <= 1'b0;
            lk_tx_act_reg <= 1'b0;
            lk_dmy_reg <= 1'b0;
            lk_dcnt_reg <= 4'h0;
            lk_rx_pend_reg <= 1'b0;
            lk_rx_tgl_reg <= 1'b0;
            lk_rx_hold_reg <= 8'h00;
            lk_ack_tgl_reg <= 1'b0;
        end else begin
            lk_sh_reg <= lk_sh_next;
            lk_bit_reg <= lk_bit_next;
            lk_so_reg <= lk_so_next;
            lk_tx_act_reg <= lk_tx_act_next;
            lk_dmy_reg <= lk_dmy_next;
            lk_dcnt_reg <= lk_dcnt_next;
            lk_rx_pend_reg <= lk_rx_pend_next;
            lk_rx_tgl_reg <= lk_rx_tgl_next;
            lk_rx_hold_reg <= lk_rx_hold_next;
            lk_ack_tgl_reg <= lk_ack_tgl_next;
        end
    end
endmodule
